/* File: verilog/acmp_cfg.svh */
// constants for the analog comparator control and status block
`ifndef ACMP_CFG_SVH
`define ACMP_CFG_SVH

`define ACMP_CON0_BASE    8'h00
`define ACMP_CON1_BASE    8'h10
`define ACMP_STAT_BASE    8'h20
`define ACMP_IRQ_BASE     8'h30
`define ACMP_IRQ_ST_OFF   8'h30
`define ACMP_IRQ_MASK_OFF 8'h34
`define ACMP_CLR_OFF      2'h1
`define ACMP_SET_OFF      2'h2
`define ACMP_INV_OFF      2'h3

`define ACMP_CON_ON       15
`define ACMP_CON_PIN_EN   14
`define ACMP_CON_POL_INV  13
`define ACMP_CON_RESULT   8
`define ACMP_CON_EV_HI    7
`define ACMP_CON_EV_LO    6
`define ACMP_CON_POS_SEL  4
`define ACMP_CON_NEG_HI   1
`define ACMP_CON_NEG_LO   0
`define ACMP_CON_WMASK    32'h0000_e0d3

`define ACMP_STAT_FREEZE  14
`define ACMP_STAT_IDLE    13
`define ACMP_STAT_WMASK   32'h0000_6000
`define ACMP_STAT_SMASK   32'h0000_2000

`define ACMP_RESET_VAL    32'h0000_0000
`define ACMP_LVL_W        10

`endif

/* File: verilog/acmp_pkg.sv */
// types shared by the comparator controller and its channels
package acmp_pkg;
	typedef logic [9:0] acmp_lvl_t;
	typedef enum logic [1:0] {
		ACMP_EV_NONE,
		ACMP_EV_RISE,
		ACMP_EV_FALL,
		ACMP_EV_ANY
	} acmp_evsel_t;
	typedef enum logic [1:0] {
		ACMP_OP_WRITE,
		ACMP_OP_CLR,
		ACMP_OP_SET,
		ACMP_OP_INV
	} acmp_op_t;
	typedef enum logic [1:0] {
		ACMP_NEG_PIN,
		ACMP_NEG_OWN_POS,
		ACMP_NEG_ALT_POS,
		ACMP_NEG_BANDGAP
	} acmp_negsel_t;
endpackage

/* File: verilog/acmp_chan_if.sv */
// configuration and result bundle between controller and one channel
`timescale 1ns/1ps
interface acmp_chan_if;
	import acmp_pkg::*;
	logic         on;
	logic         pol;
	logic         coe;
	logic         cref;
	acmp_negsel_t negsel;
	acmp_evsel_t  evsel;
	logic         stop;
	logic         freeze;
	acmp_lvl_t    pos_pin;
	acmp_lvl_t    neg_pin;
	acmp_lvl_t    alt_pin;
	acmp_lvl_t    prog_ref;
	acmp_lvl_t    bandgap;
	logic         result;
	logic         pin;
	logic         pin_oe;
	logic         event_hit;
	modport ctrl (
		output on, pol, coe, cref, negsel, evsel, stop, freeze,
		output pos_pin, neg_pin, alt_pin, prog_ref, bandgap,
		input  result, pin, pin_oe, event_hit
	);
	modport chan (
		input  on, pol, coe, cref, negsel, evsel, stop, freeze,
		input  pos_pin, neg_pin, alt_pin, prog_ref, bandgap,
		output result, pin, pin_oe, event_hit
	);
endinterface

/* File: verilog/acmp_channel.sv */
// one comparator: input muxing, compare, polarity, freeze and edge events
`timescale 1ns/1ps
module acmp_channel (
	// clock and reset
	input  wire logic clk_i,
	input  wire logic rst_i,
	// controller side
	acmp_chan_if.chan ch
);
	import acmp_pkg::*;

	acmp_lvl_t plus_lvl;
	acmp_lvl_t minus_lvl;
	logic      live;
	logic      held_reg;
	logic      prev_reg;

	assign plus_lvl = ch.cref ? ch.prog_ref : ch.pos_pin;

	always_comb begin
		unique case (ch.negsel)
			ACMP_NEG_PIN:     minus_lvl = ch.neg_pin;
			ACMP_NEG_OWN_POS: minus_lvl = ch.pos_pin;
			ACMP_NEG_ALT_POS: minus_lvl = ch.alt_pin;
			ACMP_NEG_BANDGAP: minus_lvl = ch.bandgap;
		endcase
	end

	// equal levels compare low before the polarity flip; real silicon is undefined there
	assign live = (ch.on && !ch.stop) ?
		((plus_lvl > minus_lvl) ^ ch.pol) : 1'b0;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			held_reg <= 1'b0;
		end else if (!ch.freeze) begin
			held_reg <= live;
		end
	end

	assign ch.result = ch.freeze ? held_reg : live;
	// pin path bypasses every flop except the freeze hold, so the pin sees raw comparator timing
	assign ch.pin    = ch.coe & ch.result;
	assign ch.pin_oe = ch.coe;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			prev_reg <= 1'b0;
		end else begin
			prev_reg <= ch.result;
		end
	end

	always_comb begin
		unique case (ch.evsel)
			ACMP_EV_NONE: ch.event_hit = 1'b0;
			ACMP_EV_RISE: ch.event_hit = ch.result & ~prev_reg;
			ACMP_EV_FALL: ch.event_hit = ~ch.result & prev_reg;
			ACMP_EV_ANY:  ch.event_hit = ch.result ^ prev_reg;
		endcase
	end

	a_freeze_holds: assert property (@(posedge clk_i) disable iff (rst_i)
		ch.freeze && $past(ch.freeze) |-> $stable(ch.result))
		else $error("result moved while frozen");
endmodule

/* File: verilog/acmp_ctrl.sv */
// comparator control, status and interrupt registers behind wishbone
`timescale 1ns/1ps
`include "acmp_cfg.svh"
module acmp_ctrl (
	// clock and reset
	input  wire logic                      clk_i,
	input  wire logic                      rst_i,
	// wishbone slave
	input  wire logic                      wb_cyc_i,
	input  wire logic                      wb_stb_i,
	input  wire logic                      wb_we_i,
	input  wire logic [7:0]                wb_adr_i,
	input  wire logic [31:0]               wb_dat_i,
	input  wire logic [3:0]                wb_sel_i,
	output logic      [31:0]               wb_dat_o,
	output logic                           wb_ack_o,
	// analog levels, digitised
	input  wire acmp_pkg::acmp_lvl_t [1:0] pos_pin_i,
	input  wire acmp_pkg::acmp_lvl_t [1:0] neg_pin_i,
	input  wire acmp_pkg::acmp_lvl_t       prog_ref_i,
	input  wire acmp_pkg::acmp_lvl_t       bandgap_ref_i,
	// system mode
	input  wire logic                      idle_i,
	input  wire logic                      debug_i,
	// result pins
	output logic      [1:0]                result_pin_o,
	output logic      [1:0]                result_pin_oe_o,
	// interrupt
	output logic                           irq_o
);
	import acmp_pkg::*;

	logic [31:0] con_reg [0:1];
	logic [31:0] con_next [0:1];
	logic [31:0] stat_reg;
	logic [31:0] stat_next;
	logic [1:0]  irq_st_reg;
	logic [1:0]  irq_st_next;
	logic [1:0]  irq_mask_reg;
	logic [31:0] rd_next;
	logic        ack_reg;
	logic        irq_reg;
	logic        req;
	logic        wr_go;
	logic        rd_go;
	logic [31:0] bmask;
	acmp_op_t    op;
	logic [1:0]  res;
	logic [1:0]  ev;
	logic        frz_eff;
	logic        stop_eff;
	logic [31:0] stat_view;
	logic [31:0] stat_wmask;

	acmp_chan_if ch_if [2] ();

	function automatic logic [31:0] apply_op(
		input logic [31:0] cur,
		input logic [31:0] wd,
		input logic [31:0] bm,
		input acmp_op_t    o,
		input logic [31:0] wmask
	);
		logic [31:0] w;
		logic [31:0] r;
		w = wd & bm;
		r = cur;
		unique case (o)
			ACMP_OP_WRITE: r = (cur & ~bm) | w;
			ACMP_OP_CLR:   r = cur & ~w;
			ACMP_OP_SET:   r = cur | w;
			ACMP_OP_INV:   r = cur ^ w;
		endcase
		apply_op = (r & wmask) | (cur & ~wmask);
	endfunction

	// bus decode: every request answered one cycle later
	assign req   = wb_cyc_i & wb_stb_i & ~ack_reg;
	assign wr_go = req & wb_we_i;
	assign rd_go = req & ~wb_we_i;
	assign op    = acmp_op_t'(wb_adr_i[3:2]);
	assign bmask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}},
		{8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};

	// system modes
	assign frz_eff  = stat_reg[`ACMP_STAT_FREEZE] & debug_i;
	assign stop_eff = stat_reg[`ACMP_STAT_IDLE] & idle_i;

	genvar gi;
	generate
		for (gi = 0; gi < 2; gi++) begin : g_ch
			assign ch_if[gi].on     = con_reg[gi][`ACMP_CON_ON];
			assign ch_if[gi].pol    = con_reg[gi][`ACMP_CON_POL_INV];
			assign ch_if[gi].coe    = con_reg[gi][`ACMP_CON_PIN_EN];
			assign ch_if[gi].cref   = con_reg[gi][`ACMP_CON_POS_SEL];
			assign ch_if[gi].negsel = acmp_negsel_t'(
				con_reg[gi][`ACMP_CON_NEG_HI:`ACMP_CON_NEG_LO]);
			assign ch_if[gi].evsel  = acmp_evsel_t'(
				con_reg[gi][`ACMP_CON_EV_HI:`ACMP_CON_EV_LO]);
			assign ch_if[gi].stop     = stop_eff;
			assign ch_if[gi].freeze   = frz_eff;
			assign ch_if[gi].pos_pin  = pos_pin_i[gi];
			assign ch_if[gi].neg_pin  = neg_pin_i[gi];
			// the other channel's positive pin is this one's third choice
			assign ch_if[gi].alt_pin  = pos_pin_i[1 - gi];
			assign ch_if[gi].prog_ref = prog_ref_i;
			assign ch_if[gi].bandgap  = bandgap_ref_i;
			assign res[gi]             = ch_if[gi].result;
			assign ev[gi]              = ch_if[gi].event_hit;
			// pin leaves combinationally, so only the freeze hold ever puts a flop in its path
			assign result_pin_o[gi]    = ch_if[gi].pin;
			assign result_pin_oe_o[gi] = ch_if[gi].pin_oe;

			acmp_channel u_chan (
				.clk_i (clk_i),
				.rst_i (rst_i),
				.ch    (ch_if[gi])
			);
		end
	endgenerate

	// control registers
	always_comb begin
		for (int i = 0; i < 2; i++) begin
			con_next[i] = con_reg[i];
			if (wr_go && wb_adr_i[7:4] == 4'(i)) begin
				// result bit is outside the write mask
				con_next[i] = apply_op(con_reg[i], wb_dat_i, bmask, op,
					`ACMP_CON_WMASK);
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			con_reg[0] <= `ACMP_RESET_VAL;
			con_reg[1] <= `ACMP_RESET_VAL;
		end else begin
			con_reg[0] <= con_next[0];
			con_reg[1] <= con_next[1];
		end
	end

	// shared status register
	assign stat_wmask = debug_i ? `ACMP_STAT_WMASK : `ACMP_STAT_SMASK;

	always_comb begin
		stat_next = stat_reg;
		if (wr_go && {wb_adr_i[7:4], 4'h0} == `ACMP_STAT_BASE) begin
			stat_next = apply_op(stat_reg, wb_dat_i, bmask, op,
				stat_wmask);
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			stat_reg <= `ACMP_RESET_VAL;
		end else begin
			stat_reg <= stat_next;
		end
	end

	always_comb begin
		stat_view = 32'h0000_0000;
		stat_view[`ACMP_STAT_FREEZE] = frz_eff;
		stat_view[`ACMP_STAT_IDLE]   = stat_reg[`ACMP_STAT_IDLE];
		stat_view[1:0]             = res;
	end

	// interrupt status: read of the status word clears, a new event wins
	always_comb begin
		irq_st_next = irq_st_reg;
		if (rd_go && wb_adr_i == `ACMP_IRQ_ST_OFF) begin
			irq_st_next = 2'h0;
		end
		irq_st_next = irq_st_next | ev;
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			irq_st_reg <= 2'h0;
		end else begin
			irq_st_reg <= irq_st_next;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			irq_mask_reg <= 2'h0;
		end else if (wr_go && wb_adr_i == `ACMP_IRQ_MASK_OFF
			&& wb_sel_i[0]) begin
			irq_mask_reg <= wb_dat_i[1:0];
		end
	end

	// software should mask this while reconfiguring a channel
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			irq_reg <= 1'b0;
		end else begin
			irq_reg <= |(irq_st_reg & irq_mask_reg);
		end
	end
	assign irq_o = irq_reg;

	// read mux: the result is sampled at the very edge of the read
	always_comb begin
		rd_next = 32'h0000_0000;
		unique case ({wb_adr_i[7:4], 4'h0})
			`ACMP_CON0_BASE: begin
				rd_next = con_reg[0];
				rd_next[`ACMP_CON_RESULT] = res[0];
			end
			`ACMP_CON1_BASE: begin
				rd_next = con_reg[1];
				rd_next[`ACMP_CON_RESULT] = res[1];
			end
			`ACMP_STAT_BASE: rd_next = stat_view;
			`ACMP_IRQ_BASE: begin
				if (wb_adr_i == `ACMP_IRQ_ST_OFF) begin
					rd_next = {30'h0, irq_st_reg};
				end else if (wb_adr_i == `ACMP_IRQ_MASK_OFF) begin
					rd_next = {30'h0, irq_mask_reg};
				end
			end
			default: rd_next = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_dat_o <= 32'h0000_0000;
		end else if (rd_go) begin
			wb_dat_o <= rd_next;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_reg <= 1'b0;
		end else begin
			ack_reg <= req;
		end
	end
	assign wb_ack_o = ack_reg;

	a_ack_single: assert property (@(posedge clk_i) disable iff (rst_i)
		wb_ack_o |=> !wb_ack_o)
		else $error("ack held for more than one cycle");

	a_ack_follows_req: assert property (@(posedge clk_i) disable iff (rst_i)
		wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
		else $error("request not acknowledged next cycle");

	a_read_result_now: assert property (@(posedge clk_i) disable iff (rst_i)
		rd_go && wb_adr_i == `ACMP_CON0_BASE |=>
		wb_dat_o[`ACMP_CON_RESULT] == $past(res[0]))
		else $error("read result not sampled at read edge");

	a_result_ro: assert property (@(posedge clk_i) disable iff (rst_i)
		1'b1 |-> con_reg[0][`ACMP_CON_RESULT] == 1'b0
		&& con_reg[1][`ACMP_CON_RESULT] == 1'b0)
		else $error("result bit stored by a write");

	a_set_alias: assert property (@(posedge clk_i) disable iff (rst_i)
		wr_go && wb_adr_i == (`ACMP_STAT_BASE | 8'h08) && wb_sel_i[1]
		&& wb_dat_i[`ACMP_STAT_IDLE] |=> stat_reg[`ACMP_STAT_IDLE])
		else $error("set alias failed to set idle stop");

	a_clr_alias: assert property (@(posedge clk_i) disable iff (rst_i)
		wr_go && wb_adr_i == (`ACMP_STAT_BASE | 8'h04) && wb_sel_i[1]
		&& wb_dat_i[`ACMP_STAT_IDLE] |=> !stat_reg[`ACMP_STAT_IDLE])
		else $error("clear alias failed to clear idle stop");

	a_inv_alias: assert property (@(posedge clk_i) disable iff (rst_i)
		wr_go && wb_adr_i == (`ACMP_STAT_BASE | 8'h0c) && wb_sel_i[1]
		&& wb_dat_i[`ACMP_STAT_IDLE] |=>
		stat_reg[`ACMP_STAT_IDLE] != $past(stat_reg[`ACMP_STAT_IDLE]))
		else $error("toggle alias failed to invert idle stop");

	a_idle_stops_all: assert property (@(posedge clk_i) disable iff (rst_i)
		stop_eff && !frz_eff |-> res == 2'b00)
		else $error("comparator active while idle stopped");

	a_frz_reads_zero: assert property (@(posedge clk_i) disable iff (rst_i)
		rd_go && wb_adr_i == `ACMP_STAT_BASE && !debug_i |=>
		!wb_dat_o[`ACMP_STAT_FREEZE])
		else $error("freeze bit visible outside debug");

	// a status read may legally clear the flag one cycle after the event
	a_event_sticky: assert property (@(posedge clk_i) disable iff (rst_i)
		ev[0] ##1 !(rd_go && wb_adr_i == `ACMP_IRQ_ST_OFF) |->
		irq_st_reg[0] ##1 irq_st_reg[0])
		else $error("event flag lost");

	a_irq_level: assert property (@(posedge clk_i) disable iff (rst_i)
		(irq_st_reg & irq_mask_reg) != 2'b00 |=> irq_o)
		else $error("unmasked event did not raise interrupt");

	a_irq_quiet: assert property (@(posedge clk_i) disable iff (rst_i)
		(irq_st_reg & irq_mask_reg) == 2'b00 |=> !irq_o)
		else $error("interrupt raised with no unmasked event");

	a_read_clears: assert property (@(posedge clk_i) disable iff (rst_i)
		rd_go && wb_adr_i == `ACMP_IRQ_ST_OFF && ev == 2'b00 |=>
		irq_st_reg == 2'b00)
		else $error("status read did not clear interrupt flags");

	a_pin_route_off: assert property (@(posedge clk_i) disable iff (rst_i)
		!con_reg[0][`ACMP_CON_PIN_EN] |-> !result_pin_o[0]
		&& !result_pin_oe_o[0])
		else $error("pin driven with routing off");
endmodule

/* File: verif/acmp_analog_src.sv */
// analog pins and references seen by both comparators
`timescale 1ns/1ps
module acmp_analog_src (
	// level steering from the bench
	input  wire logic [1:0]           hi_i,
	// digitised analog levels
	output acmp_pkg::acmp_lvl_t [1:0] pos_pin_o,
	output acmp_pkg::acmp_lvl_t [1:0] neg_pin_o,
	output acmp_pkg::acmp_lvl_t       prog_ref_o,
	output acmp_pkg::acmp_lvl_t       bandgap_o
);
	import acmp_pkg::*;
	// two ties: own positive vs itself, and the programmable reference vs channel 1's negative pin
	assign pos_pin_o = {hi_i[1] ? 10'h320 : 10'h12c,
	                    hi_i[0] ? 10'h258 : 10'h064};
	assign neg_pin_o = {10'h1f4, 10'h190};
	assign prog_ref_o = 10'h1f4;
	// bandgap never follows the bench
	assign bandgap_o = 10'h2bc;
endmodule

/* File: verif/tb_top.sv */
// register-level bench for the comparator controller over wishbone
`timescale 1ns/1ps
module tb_top;
	logic                       clk_i, rst_i, cyc, stb, we, ack;
	logic                       idle, dbg, irq;
	logic [7:0]                 adr;
	logic [31:0]                wdat, rdo, rdat;
	logic [3:0]                 sel;
	logic [1:0]                 hi, pin, oe;
	acmp_pkg::acmp_lvl_t [1:0]  pos, neg;
	acmp_pkg::acmp_lvl_t        pref, bg;
	int                         n_errors, tests_run, cycles, i;
	logic [15:0] cfg [8] = '{16'h8000, 16'h8001, 16'h8002, 16'h8003,
	                         16'h8010, 16'h8013, 16'ha000, 16'h0000};
	logic [7:0]                 res = 8'h15;

	acmp_ctrl dut_u (
		.clk_i(clk_i), .rst_i(rst_i),
		.wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
		.wb_dat_i(wdat), .wb_sel_i(sel), .wb_dat_o(rdo), .wb_ack_o(ack),
		.pos_pin_i(pos), .neg_pin_i(neg), .prog_ref_i(pref),
		.bandgap_ref_i(bg), .idle_i(idle), .debug_i(dbg),
		.result_pin_o(pin), .result_pin_oe_o(oe), .irq_o(irq)
	);
	acmp_analog_src src_u (
		.hi_i(hi), .pos_pin_o(pos), .neg_pin_o(neg),
		.prog_ref_o(pref), .bandgap_o(bg)
	);

	initial begin
		clk_i = 1'b0;
		forever #2 clk_i = ~clk_i;
	end

	task automatic conclude();
		if (n_errors == 0 && tests_run > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	always @(posedge clk_i) begin
		cycles <= cycles + 1;
		// whole run needs under 500 cycles
		if (cycles == 20000) begin
			n_errors++;
			conclude();
		end
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			n_errors++;
			$display("wrong value at %0t: got %h want %h", $time, got, exp);
		end
	endtask

	// request held until ack is seen at an edge, then one idle cycle
	task automatic xfer(input logic [7:0] a, input logic w,
	                    input logic [31:0] d, input logic [3:0] s);
		int n;
		n = 0;
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= d;
		sel <= s;
		do begin
			@(posedge clk_i);
			n++;
		end while (ack !== 1'b1 && n < 64);
		chk({31'h0, ack}, 32'h1);
		rdat = rdo;
		cyc <= 1'b0;
		stb <= 1'b0;
		we <= 1'b0;
		@(posedge clk_i);
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		xfer(a, 1'b1, d, 4'hf);
	endtask

	task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
		xfer(a, 1'b0, 32'h0, 4'hf);
		chk(rdat, e);
	endtask

	// settling wait after a change, as software must allow
	task automatic wt();
		repeat (4) @(posedge clk_i);
	endtask

	initial begin
		{cyc, stb, we, idle, dbg} = 5'h0;
		{adr, wdat, sel, hi} = '0;
		{n_errors, tests_run, cycles} = '0;
		rst_i = 1'b1;
		repeat (12) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		rd_chk(8'h00, 32'h0);
		rd_chk(8'h20, 32'h0);
		hi <= 2'b01;
		for (i = 0; i < 8; i++) begin
			wr(8'h00, {16'h0, cfg[i]});
			wt();
			rd_chk(8'h00, {16'h0, cfg[i]} | ({31'h0, res[i]} << 8));
			rd_chk(8'h20, {31'h0, res[i]});
		end
		hi <= 2'b11;
		wr(8'h10, 32'h8000);
		wt();
		rd_chk(8'h10, 32'h8100);
		rd_chk(8'h20, 32'h2);
		wr(8'h10, 32'h0);
		wr(8'h00, 32'hffff_ffff);
		wt();
		rd_chk(8'h00, 32'he1d3);
		xfer(8'h00, 1'b1, 32'h8001, 4'h1);
		rd_chk(8'h00, 32'he101);
		wr(8'h00, 32'h8000);
		wr(8'h08, 32'h4000);
		wt();
		rd_chk(8'h00, 32'hc100);
		chk({30'h0, oe, pin}, 32'h5);
		hi <= 2'b00;
		// no rising edge in between: a flopped pin would still be high
		@(negedge clk_i);
		chk({31'h0, pin[0]}, 32'h0);
		@(posedge clk_i);
		wr(8'h04, 32'h4000);
		chk({31'h0, oe[0]}, 32'h0);
		hi <= 2'b01;
		wt();
		idle <= 1'b1;
		wt();
		rd_chk(8'h20, 32'h1);
		wr(8'h28, 32'h2000);
		wt();
		rd_chk(8'h20, 32'h2000);
		wr(8'h2c, 32'h2000);
		wt();
		rd_chk(8'h20, 32'h1);
		wr(8'h2c, 32'h2000);
		wr(8'h24, 32'hffff_ffff);
		wt();
		rd_chk(8'h20, 32'h1);
		wr(8'h20, 32'hffff_ffff);
		rd_chk(8'h20, 32'h2000);
		wr(8'h24, 32'h2000);
		idle <= 1'b0;
		dbg <= 1'b1;
		wr(8'h28, 32'h4000);
		rd_chk(8'h20, 32'h4001);
		hi <= 2'b00;
		wt();
		rd_chk(8'h00, 32'h8100);
		dbg <= 1'b0;
		wt();
		rd_chk(8'h20, 32'h0);
		dbg <= 1'b1;
		wr(8'h24, 32'h4000);
		dbg <= 1'b0;
		wr(8'h28, 32'h4000);
		dbg <= 1'b1;
		rd_chk(8'h20, 32'h0);
		dbg <= 1'b0;
		for (i = 0; i < 5; i++) begin
			// line masked across each change; last pass stays masked
			wr(8'h34, 32'h0);
			wr(8'h00, 32'h8000 | ((i > 3 ? 3 : i) << 6));
			wt();
			xfer(8'h30, 1'b0, 32'h0, 4'hf);
			rd_chk(8'h30, 32'h0);
			if (i < 4)
				wr(8'h34, 32'h3);
			rd_chk(8'h34, (i < 4) ? 32'h3 : 32'h0);
			hi <= 2'b01;
			wt();
			chk({31'h0, irq}, i == 1 || i == 3);
			rd_chk(8'h30, i == 1 || i >= 3);
			hi <= 2'b00;
			wt();
			chk({31'h0, irq}, i == 2 || i == 3);
			rd_chk(8'h30, i >= 2);
		end
		wr(8'h40, 32'hffff_ffff);
		rd_chk(8'h40, 32'h0);
		conclude();
	end
endmodule
